// ---- src/mcrb_regs.vh ----
// Purpose: Offsets, field positions, reset values for the MAC command register bank
// Assumes: Byte addresses on an 8-bit register offset
// Notes:   Included by the bank and its storage module
`ifndef MCRB_REGS_VH
`define MCRB_REGS_VH

// Register offsets
`define MCRB_OFS_CMD        8'h00
`define MCRB_OFS_CFG        8'h04
`define MCRB_OFS_PROM       8'h08
`define MCRB_OFS_BUSTEST    8'h0c
`define MCRB_OFS_ISTAT      8'h10
`define MCRB_OFS_IMASK      8'h14
`define MCRB_OFS_IENA       8'h18
`define MCRB_OFS_PHY        8'h1c
`define MCRB_OFS_TXDESC     8'h20
`define MCRB_OFS_TX_CONFIGURATION      8'h24
`define MCRB_OFS_RXDESC     8'h30
`define MCRB_OFS_RX_CONFIGURATION      8'h34
`define MCRB_OFS_PAUSE      8'h38
`define MCRB_OFS_FILTCTL    8'h48
`define MCRB_OFS_FILTDAT    8'h4c
`define MCRB_OFS_PWRCTL     8'hb0
`define MCRB_OFS_WAKEEVT    8'hb4
`define MCRB_OFS_WAKECHK    8'hbc
`define MCRB_OFS_WMASK_LO   8'hc0
`define MCRB_OFS_WMASK_HI   8'hec

// Storage word indices
`define MCRB_IDX_WMASK_BASE 5'd14
`define MCRB_STORE_WORDS    26

// Command register fields
`define MCRB_CMD_SOFT_RESET 8
`define MCRB_CMD_SW_IRQ     7
`define MCRB_CMD_RX_RESET   5
`define MCRB_CMD_TX_RESET   4
`define MCRB_CMD_RX_DIS     3
`define MCRB_CMD_RX_ENA     2
`define MCRB_CMD_TX_DIS     1
`define MCRB_CMD_TX_ENA     0

// Interrupt status fields
`define MCRB_IST_SW_IRQ     7
`define MCRB_IST_RX_RCMP    24
`define MCRB_IST_TX_RCMP    25

// Interrupt enable field
`define MCRB_IEN_GLOBAL     0

// Reset values
`define MCRB_CMD_RESET      32'h00000000
`define MCRB_ISTAT_RESET    32'h00000000
`define MCRB_IMASK_RESET    32'h00000000
`define MCRB_IENA_RESET     32'h00000000
`define MCRB_STORE_RESET    32'h00000000

`endif

// ---- src/mcrb_store.v ----
// Purpose: Word store for the plain read/write registers of the bank
// Assumes: One clock, synchronous reset, byte lane write enables
// Notes:   Read data is registered; soft clear empties every word
`timescale 1ns/1ps
`default_nettype none
`include "mcrb_regs.vh"

module mcrb_store #(
  parameter WORDS  = `MCRB_STORE_WORDS,
  parameter AWIDTH = 5
) (
  // Clock and reset
  input  wire              MCLK,
  input  wire              RST,
  // Soft reset clear
  input  wire              CLEAR,
  // Write port
  input  wire              WR_EN,
  input  wire [AWIDTH-1:0] WR_ADDR,
  input  wire [3:0]        WR_BE,
  input  wire [31:0]       WR_DATA,
  // Read port
  input  wire [AWIDTH-1:0] RD_ADDR,
  output reg  [31:0]       RD_DATA
);

  reg [31:0] mem_q [0:WORDS-1];
  integer    i;
  integer    b;

  always @(posedge MCLK) begin
    if (RST || CLEAR) begin
      for (i = 0; i < WORDS; i = i + 1) begin
        mem_q[i] <= `MCRB_STORE_RESET;
      end
    end else if (WR_EN) begin
      for (b = 0; b < 4; b = b + 1) begin
        if (WR_BE[b]) begin
          mem_q[WR_ADDR][8*b +: 8] <= WR_DATA[8*b +: 8];
        end
      end
    end
  end

  always @(posedge MCLK) begin
    if (RST) begin
      RD_DATA <= 32'h00000000;
    end else begin
      RD_DATA <= mem_q[RD_ADDR];
    end
  end

endmodule // mcrb_store

`default_nettype wire

// ---- src/mcrb_bank.v ----
// Purpose: Operational register window of a PCI Fast Ethernet MAC, around its command register
// Assumes: PCI target logic presents decoded single-word accesses on MCLK; engines answer on MCLK
// Notes:   Read data valid one cycle after the read strobe
//          Status is read-to-clear; an event in the clearing cycle survives
`timescale 1ns/1ps
`default_nettype none
`include "mcrb_regs.vh"

module mcrb_bank (
  // Clock and reset
  input  wire        MCLK,
  input  wire        RST,
  // Register access from the PCI target
  input  wire        REG_MEM_SEL,
  input  wire        REG_IO_SEL,
  input  wire [7:0]  REG_ADDR,
  input  wire        REG_WR,
  input  wire        REG_RD,
  input  wire [3:0]  REG_BE,
  input  wire [31:0] REG_WDATA,
  output reg  [31:0] REG_RDATA,
  output reg         REG_RVALID,
  // Transmit engine handshake
  output reg         TX_RESET,
  input  wire        TX_RESET_ACK,
  output reg         TX_ENABLE,
  output reg         TX_STOP,
  input  wire        TX_IDLE,
  // Receive engine handshake
  output reg         RX_RESET,
  input  wire        RX_RESET_ACK,
  output reg         RX_ENABLE,
  output reg         RX_STOP,
  input  wire        RX_IDLE,
  // Soft reset and interrupt
  output wire        SOFT_RESET_BUSY,
  output reg         IRQ
);

  // Soft reset sequencer states
  localparam [2:0] SR_IDLE  = 3'b001;
  localparam [2:0] SR_CLEAR = 3'b010;
  localparam [2:0] SR_WAIT  = 3'b100;

  // Map an offset to a storage word; bit 5 flags a hit
  // Wake masks take words 14 to 25, one per dword
  function [5:0] store_map;
    input [7:0] ofs;
    begin
      case (ofs)
        `MCRB_OFS_CFG:     store_map = {1'b1, 5'd0};
        `MCRB_OFS_PROM:    store_map = {1'b1, 5'd1};
        `MCRB_OFS_BUSTEST: store_map = {1'b1, 5'd2};
        `MCRB_OFS_PHY:     store_map = {1'b1, 5'd3};
        `MCRB_OFS_TXDESC:  store_map = {1'b1, 5'd4};
        `MCRB_OFS_TX_CONFIGURATION:   store_map = {1'b1, 5'd5};
        `MCRB_OFS_RXDESC:  store_map = {1'b1, 5'd6};
        `MCRB_OFS_RX_CONFIGURATION:   store_map = {1'b1, 5'd7};
        `MCRB_OFS_PAUSE:   store_map = {1'b1, 5'd8};
        `MCRB_OFS_FILTCTL: store_map = {1'b1, 5'd9};
        `MCRB_OFS_FILTDAT: store_map = {1'b1, 5'd10};
        `MCRB_OFS_PWRCTL:  store_map = {1'b1, 5'd11};
        `MCRB_OFS_WAKEEVT: store_map = {1'b1, 5'd12};
        `MCRB_OFS_WAKECHK: store_map = {1'b1, 5'd13};
        default: begin
          if (ofs >= `MCRB_OFS_WMASK_LO && ofs <= `MCRB_OFS_WMASK_HI && ofs[1:0] == 2'b00) begin
            store_map = {1'b1, `MCRB_IDX_WMASK_BASE + {1'b0, ofs[5:2]}};
          end else begin
            store_map = 6'h00;
          end
        end
      endcase
    end
  endfunction

  // Byte-lane merge for registers kept in this module
  function [31:0] lane_merge;
    input [31:0] old;
    input [31:0] wdat;
    input [3:0]  be;
    integer      k;
    begin
      lane_merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (be[k]) begin
          lane_merge[8*k +: 8] = wdat[8*k +: 8];
        end
      end
    end
  endfunction

  // Command read-back: strobe bits read zero; only busy and active states show
  function [31:0] cmd_view;
    input busy;
    input rx_on;
    input tx_on;
    begin
      cmd_view                       = 32'h00000000;
      cmd_view[`MCRB_CMD_SOFT_RESET] = busy;
      cmd_view[`MCRB_CMD_RX_ENA]     = rx_on;
      cmd_view[`MCRB_CMD_TX_ENA]     = tx_on;
    end
  endfunction

  // Bus decode; either address space selects the same window
  wire        sel       = REG_MEM_SEL | REG_IO_SEL;
  wire        wr_take   = sel & REG_WR;
  wire        rd_take   = sel & REG_RD;
  wire [5:0]  map       = store_map(REG_ADDR);
  wire        hit_cmd   = (REG_ADDR == `MCRB_OFS_CMD);
  wire        hit_istat = (REG_ADDR == `MCRB_OFS_ISTAT);
  wire        hit_imask = (REG_ADDR == `MCRB_OFS_IMASK);
  wire        hit_iena  = (REG_ADDR == `MCRB_OFS_IENA);
  wire        cmd_wr    = wr_take & hit_cmd;
  wire        store_wr  = wr_take & map[5];

  // Command bits as written; only lanes 0 and 1 carry commands
  wire        w_lo      = cmd_wr & REG_BE[0];
  wire        w_soft    = cmd_wr & REG_BE[1] & REG_WDATA[`MCRB_CMD_SOFT_RESET];
  wire        w_swi     = w_lo & REG_WDATA[`MCRB_CMD_SW_IRQ];
  wire        w_rxr     = w_lo & REG_WDATA[`MCRB_CMD_RX_RESET];
  wire        w_txr     = w_lo & REG_WDATA[`MCRB_CMD_TX_RESET];
  wire        w_rxd     = w_lo & REG_WDATA[`MCRB_CMD_RX_DIS];
  wire        w_rxe     = w_lo & REG_WDATA[`MCRB_CMD_RX_ENA];
  wire        w_txd     = w_lo & REG_WDATA[`MCRB_CMD_TX_DIS];
  wire        w_txe     = w_lo & REG_WDATA[`MCRB_CMD_TX_ENA];

  // Registered state
  reg  [2:0]  sr_q;
  reg  [2:0]  sr_d;
  reg  [31:0] istat_q;
  reg  [31:0] istat_d;
  reg  [31:0] imask_q;
  reg  [31:0] iena_q;
  reg  [1:0]  rd_src_q;
  reg  [31:0] local_rdata_q;
  wire [31:0] store_rdata;

  wire soft_start = (sr_q == SR_IDLE) & w_soft;
  wire soft_clear = (sr_q == SR_CLEAR);
  wire tx_ack     = TX_RESET & TX_RESET_ACK;
  wire rx_ack     = RX_RESET & RX_RESET_ACK;

  assign SOFT_RESET_BUSY = (sr_q != SR_IDLE);

  // Soft reset sequencer
  always @* begin
    case (sr_q)
      SR_IDLE:  sr_d = soft_start ? SR_CLEAR : SR_IDLE;
      // One cycle to clear storage while the engines start their resets
      SR_CLEAR: sr_d = SR_WAIT;
      // Busy until both engines have answered; no timeout, a silent engine keeps busy set
      SR_WAIT:  sr_d = (!TX_RESET && !RX_RESET) ? SR_IDLE : SR_WAIT;
      default:  sr_d = SR_IDLE;
    endcase
  end

  always @(posedge MCLK) begin
    if (RST) begin
      sr_q <= SR_IDLE;
    end else begin
      sr_q <= sr_d;
    end
  end

  // Engine resets: held until the engine acknowledges; a new request beats the ack
  always @(posedge MCLK) begin
    if (RST) begin
      TX_RESET <= 1'b0;
      RX_RESET <= 1'b0;
    end else begin
      if (soft_start || w_txr) begin
        TX_RESET <= 1'b1;
      end else if (TX_RESET_ACK) begin
        TX_RESET <= 1'b0;
      end
      if (soft_start || w_rxr) begin
        RX_RESET <= 1'b1;
      end else if (RX_RESET_ACK) begin
        RX_RESET <= 1'b0;
      end
    end
  end

  // Transmit enable and stop
  // Enable writes are dropped while the engine reset is pending
  always @(posedge MCLK) begin
    if (RST) begin
      TX_ENABLE <= 1'b0;
      TX_STOP   <= 1'b0;
    end else if (soft_start || w_txr || TX_RESET) begin
      TX_ENABLE <= 1'b0;
      TX_STOP   <= 1'b0;
    end else if (w_txd) begin
      // Disable wins; enable in the same write is dropped
      TX_STOP   <= TX_ENABLE;
    end else if (TX_STOP && TX_IDLE) begin
      TX_ENABLE <= 1'b0;
      TX_STOP   <= 1'b0;
    end else if (w_txe && !TX_ENABLE) begin
      TX_ENABLE <= 1'b1;
    end
  end

  // Receive enable and stop
  // Same priorities as the transmit side
  always @(posedge MCLK) begin
    if (RST) begin
      RX_ENABLE <= 1'b0;
      RX_STOP   <= 1'b0;
    end else if (soft_start || w_rxr || RX_RESET) begin
      RX_ENABLE <= 1'b0;
      RX_STOP   <= 1'b0;
    end else if (w_rxd) begin
      RX_STOP   <= RX_ENABLE;
    end else if (RX_STOP && RX_IDLE) begin
      RX_ENABLE <= 1'b0;
      RX_STOP   <= 1'b0;
    end else if (w_rxe && !RX_ENABLE) begin
      RX_ENABLE <= 1'b1;
    end
  end

  // Interrupt status: clears first, then events, so an event in the clearing cycle survives
  always @* begin
    istat_d = istat_q;
    if (soft_clear || (rd_take && hit_istat)) begin
      istat_d = `MCRB_ISTAT_RESET;
    end
    if (w_swi) begin
      istat_d[`MCRB_IST_SW_IRQ] = 1'b1;
    end
    if (tx_ack) begin
      istat_d[`MCRB_IST_TX_RCMP] = 1'b1;
    end
    if (rx_ack) begin
      istat_d[`MCRB_IST_RX_RCMP] = 1'b1;
    end
  end

  always @(posedge MCLK) begin
    if (RST) begin
      istat_q <= `MCRB_ISTAT_RESET;
    end else begin
      istat_q <= istat_d;
    end
  end

  // Mask: which status bits may reach the interrupt line
  always @(posedge MCLK) begin
    if (RST || soft_clear) begin
      imask_q <= `MCRB_IMASK_RESET;
    end else if (wr_take && hit_imask) begin
      imask_q <= lane_merge(imask_q, REG_WDATA, REG_BE);
    end
  end

  // Global enable in bit 0; the other bits are plain storage
  always @(posedge MCLK) begin
    if (RST || soft_clear) begin
      iena_q <= `MCRB_IENA_RESET;
    end else if (wr_take && hit_iena) begin
      iena_q <= lane_merge(iena_q, REG_WDATA, REG_BE);
    end
  end

  // Level output, one cycle behind the status that drives it
  always @(posedge MCLK) begin
    if (RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= iena_q[`MCRB_IEN_GLOBAL] & (|(istat_q & imask_q));
    end
  end

  // Plain registers; unmapped offsets never reach storage
  mcrb_store #(
    .WORDS  (`MCRB_STORE_WORDS),
    .AWIDTH (5)
  ) u_store (
    .MCLK    (MCLK),
    .RST     (RST),
    .CLEAR   (soft_clear),
    .WR_EN   (store_wr),
    .WR_ADDR (map[4:0]),
    .WR_BE   (REG_BE),
    .WR_DATA (REG_WDATA),
    .RD_ADDR (map[4:0]),
    .RD_DATA (store_rdata)
  );

  // Read path, one cycle latency for both sources
  always @(posedge MCLK) begin
    if (RST) begin
      rd_src_q      <= 2'b00;
      local_rdata_q <= 32'h00000000;
      REG_RVALID    <= 1'b0;
    end else begin
      REG_RVALID <= rd_take;
      rd_src_q   <= {rd_take & map[5], rd_take & ~map[5]};
      if (hit_cmd) begin
        // Strobe bits read zero; only busy and active states show
        local_rdata_q <= cmd_view(SOFT_RESET_BUSY, RX_ENABLE, TX_ENABLE);
      end else if (hit_istat) begin
        local_rdata_q <= istat_q;
      end else if (hit_imask) begin
        local_rdata_q <= imask_q;
      end else if (hit_iena) begin
        local_rdata_q <= iena_q;
      end else begin
        local_rdata_q <= 32'h00000000;
      end
    end
  end

  always @* begin
    REG_RDATA = rd_src_q[1] ? store_rdata : (rd_src_q[0] ? local_rdata_q : 32'h00000000);
  end

endmodule // mcrb_bank

`default_nettype wire

// ---- tb/mcrb_bank_asserts.sv ----
// Purpose: Port-level checks for the command register bank
// Assumes: One clock MCLK, synchronous active-high RST
// Notes:   Bound to every mcrb_bank instance
`timescale 1ns/1ps
`default_nettype none
module mcrb_bank_asserts (
  // Clock and reset
  input wire logic        MCLK,
  input wire logic        RST,
  // Register access
  input wire logic        REG_MEM_SEL,
  input wire logic        REG_IO_SEL,
  input wire logic [7:0]  REG_ADDR,
  input wire logic        REG_WR,
  input wire logic        REG_RD,
  input wire logic [3:0]  REG_BE,
  input wire logic [31:0] REG_WDATA,
  input wire logic        REG_RVALID,
  // Engine handshakes
  input wire logic        TX_RESET,
  input wire logic        TX_ENABLE,
  input wire logic        TX_STOP,
  input wire logic        TX_IDLE,
  input wire logic        RX_RESET,
  input wire logic        RX_ENABLE,
  input wire logic        RX_STOP,
  input wire logic        RX_IDLE,
  input wire logic        SOFT_RESET_BUSY
);
  wire logic acc    = REG_MEM_SEL | REG_IO_SEL;
  wire logic cmd_lo = acc & REG_WR & (REG_ADDR == 8'h00) & REG_BE[0];
  wire logic cmd_hi = acc & REG_WR & (REG_ADDR == 8'h00) & REG_BE[1];
  // A reset in the same write would rightly override the start
  wire logic tx_go  = cmd_lo & REG_WDATA[0] & ~REG_WDATA[1] & ~REG_WDATA[4] & ~(cmd_hi & REG_WDATA[8]);
  // A second soft reset while busy is ignored
  wire logic soft_go = cmd_hi & REG_WDATA[8] & ~SOFT_RESET_BUSY;
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RST);
  a_read_answered: assert property (acc && REG_RD |=> REG_RVALID) else $error("read not answered");
  a_answer_cause: assert property (REG_RVALID |-> $past(acc && REG_RD)) else $error("stray read answer");
  a_soft_reset_go: assert property (soft_go |=> SOFT_RESET_BUSY && TX_RESET && RX_RESET)
    else $error("soft reset not started");
  a_busy_ends: assert property (SOFT_RESET_BUSY && !TX_RESET && !RX_RESET |-> ##[1:2] !SOFT_RESET_BUSY)
    else $error("busy stuck");
  a_tx_reset_kill: assert property (cmd_lo && REG_WDATA[4] |=> TX_RESET && !TX_ENABLE)
    else $error("tx reset ignored");
  a_rx_reset_kill: assert property (cmd_lo && REG_WDATA[5] |=> RX_RESET && !RX_ENABLE)
    else $error("rx reset ignored");
  a_tx_start: assert property (tx_go && !TX_ENABLE && !TX_RESET |=> TX_ENABLE) else $error("tx not started");
  a_tx_dis_wins: assert property (cmd_lo && REG_WDATA[1:0] == 2'b11 && !TX_ENABLE |=> !TX_ENABLE)
    else $error("tx enable won");
  a_rx_dis_wins: assert property (cmd_lo && REG_WDATA[3:2] == 2'b11 && !RX_ENABLE |=> !RX_ENABLE)
    else $error("rx enable won");
  a_stop_waits: assert property (TX_STOP && !TX_IDLE && !cmd_lo && !cmd_hi |=> TX_ENABLE)
    else $error("tx cut mid packet");
  a_tx_stop_done: assert property (TX_STOP && TX_IDLE && !cmd_lo |=> !TX_ENABLE && !TX_STOP)
    else $error("tx stop stuck");
  a_rx_stop_done: assert property (RX_STOP && RX_IDLE && !cmd_lo |=> !RX_ENABLE && !RX_STOP)
    else $error("rx stop stuck");
  c_soft_reset: cover property (cmd_hi && REG_WDATA[8]);
  c_tx_stop_wait: cover property (TX_STOP && !TX_IDLE);
  c_rx_stop_wait: cover property (RX_STOP && !RX_IDLE);
endmodule // mcrb_bank_asserts
bind mcrb_bank mcrb_bank_asserts u_chk (.MCLK(MCLK), .RST(RST), .REG_MEM_SEL(REG_MEM_SEL), .REG_IO_SEL(REG_IO_SEL),
  .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_BE(REG_BE), .REG_WDATA(REG_WDATA),
  .REG_RVALID(REG_RVALID), .TX_RESET(TX_RESET), .TX_ENABLE(TX_ENABLE), .TX_STOP(TX_STOP), .TX_IDLE(TX_IDLE),
  .RX_RESET(RX_RESET), .RX_ENABLE(RX_ENABLE), .RX_STOP(RX_STOP), .RX_IDLE(RX_IDLE),
  .SOFT_RESET_BUSY(SOFT_RESET_BUSY));
`default_nettype wire

// ---- tb/mcrb_engine_model.sv ----
// Purpose: Behavioural transmit or receive engine facing the bank
// Assumes: Same clock as the bank
// Notes:   DLY sets how slowly a reset request is acknowledged
`timescale 1ns/1ps
`default_nettype none
module mcrb_engine_model #(
  parameter int DLY = 2
) (
  // Clock and reset
  input  wire logic MCLK,
  input  wire logic RST,
  // Bank handshake
  input  wire logic REQ,
  output logic      ACK,
  output logic      IDLE,
  // Bench control: packet in flight
  input  wire logic HOLD
);
  logic [3:0] cnt_q;
  assign IDLE = ~HOLD;
  // Flush counts DLY cycles and ack rises one cycle later; ack stays up until the request drops
  always @(posedge MCLK) begin
    if (RST || !REQ) begin
      cnt_q <= 4'h0;
      ACK   <= 1'b0;
    end else begin
      if (cnt_q != 4'(DLY)) begin
        cnt_q <= cnt_q + 4'h1;
      end
      ACK <= (cnt_q == 4'(DLY));
    end
  end
endmodule // mcrb_engine_model
`default_nettype wire

// ---- tb/tb_mac_command_register_bank.sv ----
// Purpose: Self-checking bench for the command register bank
// Assumes: Engines modelled, one prompt and one slow
// Notes:   Host polls reset-complete before enabling
`timescale 1ns/1ps
`default_nettype none
`include "mcrb_regs.vh"
module tb_mac_command_register_bank;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        mem_sel = 1'b0;
  logic        io_sel = 1'b0;
  logic        wr_s = 1'b0;
  logic        rd_s = 1'b0;
  logic        use_io = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [3:0]  be = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] v;
  logic [1:0]  hold = 2'b00;
  wire  [31:0] rdata;
  wire         rvalid, transmitter_reset, txa, transmitter_enable, txs, txi, receiver_reset, rxa, receiver_enable, rxs, rxi, busy, irq;
  integer      failures = 0;
  integer      tests_run = 0;
  integer      d;
  initial forever #5 clk = ~clk;
  mcrb_bank dut (.MCLK(clk), .RST(rst), .REG_MEM_SEL(mem_sel), .REG_IO_SEL(io_sel), .REG_ADDR(addr),
    .REG_WR(wr_s), .REG_RD(rd_s), .REG_BE(be), .REG_WDATA(wdat), .REG_RDATA(rdata), .REG_RVALID(rvalid),
    .TX_RESET(transmitter_reset), .TX_RESET_ACK(txa), .TX_ENABLE(transmitter_enable), .TX_STOP(txs), .TX_IDLE(txi),
    .RX_RESET(receiver_reset), .RX_RESET_ACK(rxa), .RX_ENABLE(receiver_enable), .RX_STOP(rxs), .RX_IDLE(rxi),
    .SOFT_RESET_BUSY(busy), .IRQ(irq));
  mcrb_engine_model #(.DLY(1)) u_tx (.MCLK(clk), .RST(rst), .REQ(transmitter_reset), .ACK(txa), .IDLE(txi), .HOLD(hold[0]));
  mcrb_engine_model #(.DLY(5)) u_rx (.MCLK(clk), .RST(rst), .REQ(receiver_reset), .ACK(rxa), .IDLE(rxi), .HOLD(hold[1]));
  task chk(input [31:0] g, input [31:0] e);
    tests_run = tests_run + 1;
    if (g !== e) begin
      failures = failures + 1;
      $display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task wr(input [7:0] a, input [31:0] dat, input [3:0] b);
    @(negedge clk);
    {mem_sel, io_sel, addr, wdat, be, wr_s} = {~use_io, use_io, a, dat, b, 1'b1};
    @(negedge clk);
    {mem_sel, io_sel, wr_s} = 3'b000;
  endtask
  task rd(input [7:0] a, output [31:0] r);
    @(negedge clk);
    {mem_sel, io_sel, addr, rd_s} = {~use_io, use_io, a, 1'b1};
    @(negedge clk);
    {mem_sel, io_sel, rd_s} = 3'b000;
    chk({31'h0, rvalid}, 32'h1);
    r = rdata;
  endtask
  task rdc(input [7:0] a, input [31:0] m, input [31:0] e);
    rd(a, v);
    chk(v & m, e);
  endtask
  task poll(input [7:0] a, input integer b, input w);
    integer n;
    for (n = 0; n < 40; n = n + 1) begin
      rd(a, v);
      if (v[b] === w) n = 99;
    end
    if (n == 40) begin
      failures = failures + 1;
      $display("CHECK FAILED at %0t: poll timed out", $time);
      finish_test;
    end
  endtask
  task finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    rdc(`MCRB_OFS_CMD, 32'hffffffff, 32'h0);
    rdc(`MCRB_OFS_ISTAT, 32'hffffffff, 32'h0);
    wr(8'h28, 32'hffffffff, 4'hf);
    rdc(8'h28, 32'hffffffff, 32'h0);
    wr(`MCRB_OFS_TXDESC, 32'ha5a55a5a, 4'hf);
    use_io = 1'b1;
    rdc(`MCRB_OFS_TXDESC, 32'hffffffff, 32'ha5a55a5a);
    wr(`MCRB_OFS_WMASK_HI, 32'h12345678, 4'h5);
    use_io = 1'b0;
    wr(8'hf0, 32'hffffffff, 4'hf);
    rdc(`MCRB_OFS_WMASK_HI, 32'hffffffff, 32'h00340078);
    rdc(8'hf0, 32'hffffffff, 32'h0);
    $display("TEST map done");
    // Same sequence per direction: d=0 transmit, d=1 receive
    for (d = 0; d < 2; d = d + 1) begin
      wr(`MCRB_OFS_CMD, 32'h10 << d, 4'h1);
      poll(`MCRB_OFS_ISTAT, 25 - d, 1'b1);
      wr(`MCRB_OFS_CMD, 32'h1 << 2 * d, 4'h1);
      rdc(`MCRB_OFS_CMD, 32'hffffffff, 32'h1 << 2 * d);
      wr(`MCRB_OFS_CMD, 32'h10 << d, 4'h1);
      rdc(`MCRB_OFS_CMD, 32'hffffffff, 32'h0);
      poll(`MCRB_OFS_ISTAT, 25 - d, 1'b1);
      wr(`MCRB_OFS_CMD, 32'h3 << 2 * d, 4'h1);
      rdc(`MCRB_OFS_CMD, 32'hffffffff, 32'h0);
      hold[d] = 1'b1;
      wr(`MCRB_OFS_CMD, 32'h1 << 2 * d, 4'h1);
      wr(`MCRB_OFS_CMD, 32'h2 << 2 * d, 4'h1);
      chk({31'h0, d ? rxs : txs}, 32'h1);
      rdc(`MCRB_OFS_CMD, 32'hffffffff, 32'h1 << 2 * d);
      hold[d] = 1'b0;
      repeat (3) @(negedge clk);
      rdc(`MCRB_OFS_CMD, 32'hffffffff, 32'h0);
      chk({31'h0, d ? rxs : txs}, 32'h0);
      $display("TEST direction %0d done", d);
    end
    wr(`MCRB_OFS_IMASK, 32'h80, 4'hf);
    wr(`MCRB_OFS_CMD, 32'h100, 4'h2);
    rdc(`MCRB_OFS_CMD, 32'hffffffff, 32'h100);
    chk({30'h0, busy, receiver_reset}, 32'h3);
    poll(`MCRB_OFS_CMD, 8, 1'b0);
    rdc(`MCRB_OFS_TXDESC, 32'hffffffff, 32'h0);
    rdc(`MCRB_OFS_IMASK, 32'hffffffff, 32'h0);
    rdc(`MCRB_OFS_ISTAT, 32'h03000000, 32'h03000000);
    $display("TEST soft reset done");
    wr(`MCRB_OFS_IENA, 32'h1, 4'hf);
    wr(`MCRB_OFS_IMASK, 32'h80, 4'hf);
    wr(`MCRB_OFS_CMD, 32'h80, 4'h1);
    repeat (2) @(negedge clk);
    chk({31'h0, irq}, 32'h1);
    rdc(`MCRB_OFS_CMD, 32'hffffffff, 32'h0);
    rdc(`MCRB_OFS_ISTAT, 32'h80, 32'h80);
    repeat (2) @(negedge clk);
    chk({31'h0, irq}, 32'h0);
    wr(`MCRB_OFS_IMASK, 32'h0, 4'hf);
    wr(`MCRB_OFS_CMD, 32'h80, 4'h1);
    repeat (2) @(negedge clk);
    chk({31'h0, irq}, 32'h0);
    wr(`MCRB_OFS_IENA, 32'h0, 4'hf);
    wr(`MCRB_OFS_IMASK, 32'h80, 4'hf);
    repeat (2) @(negedge clk);
    chk({31'h0, irq}, 32'h0);
    $display("TEST interrupt done");
    finish_test;
  end
endmodule // tb_mac_command_register_bank
`default_nettype wire
